/* File: design/srg_access_check.sv */
// Rights check of one command against a namespace reservation.
// Assumes the holder and registrant flags are already resolved by host.
`timescale 1ns/1ps
`include "srg_params.svh"

module srg_access_check (
  // Command
  input  wire logic                  is_read,
  // Reservation state
  input  wire srg_pkg::srg_rtype_type rtype,
  input  wire logic                  is_holder,
  input  wire logic                  is_registrant,
  // Verdict
  output logic                       allow
);

  wire excl_all = (rtype == srg_pkg::SRG_RT_EA) ||
                  (rtype == srg_pkg::SRG_RT_EA_RO) ||
                  (rtype == srg_pkg::SRG_RT_EA_AR);
  wire reg_ok   = (rtype == srg_pkg::SRG_RT_WE_RO) ||
                  (rtype == srg_pkg::SRG_RT_EA_RO) ||
                  (rtype == srg_pkg::SRG_RT_WE_AR) ||
                  (rtype == srg_pkg::SRG_RT_EA_AR);
  wire none     = (rtype == srg_pkg::SRG_RT_NONE);
  wire other_ok = is_read && !excl_all;

  assign allow = none || is_holder || (is_registrant && reg_ok) ||
                 other_ok;

endmodule

/* File: design/srg_gate.sv */
// Reservation gate: checks commands against namespace reservations.
// Assumes one command per cycle at most, presented as a pulse.
`timescale 1ns/1ps
`include "srg_params.svh"

module srg_gate (
  // Clock and reset
  input  wire logic                       CLOCK,
  input  wire logic                       RST_N,
  // Configuration
  input  wire logic                       CTRL_RES_EN,
  input  wire logic [`SRG_NUM_NS-1:0]     NS_RES_EN,
  // Host identifier set
  input  wire logic                       HID_WR,
  input  wire logic [`SRG_CTRL_W-1:0]     HID_CTRL,
  input  wire logic [`SRG_HOSTID_W-1:0]   HID_DATA,
  // Command in
  input  wire logic                       CMD_VALID,
  input  wire logic [`SRG_CTRL_W-1:0]     CMD_CTRL,
  input  wire logic [`SRG_NS_W-1:0]       CMD_NS,
  input  wire logic [7:0]                 CMD_OPCODE,
  input  wire logic [2:0]                 CMD_ACTION,
  input  wire logic [2:0]                 CMD_RTYPE,
  input  wire logic [`SRG_KEY_W-1:0]      CMD_KEY,
  input  wire logic                       CMD_POWER_LOSS_PERSISTENCE_STATE,
  input  wire logic                       CMD_POWER_LOSS_PERSISTENCE_STATE_WR,
  // Verdict out
  output logic                            DONE,
  output logic [7:0]                      STATUS,
  output logic                            MEDIA_GO,
  output logic                            NOTIFY,
  // Capabilities and persistence state
  output logic [15:0]                     OPTIONAL_COMMAND_SUPPORT_FIELD,
  output logic [8*`SRG_NUM_NS-1:0]        RESERVATION_CAPABILITY_FIELD,
  output logic [`SRG_NUM_NS-1:0]          POWER_LOSS_PERSISTENCE_STATE
);

  // ---------------------------------------------------------------
  // Host identity per controller
  // ---------------------------------------------------------------
  logic [`SRG_HOSTID_W-1:0] hid_r [`SRG_NUM_CTRL];
  logic [`SRG_NUM_CTRL-1:0] hid_set_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      hid_set_r <= '0;
    end else if (HID_WR) begin
      hid_set_r[HID_CTRL] <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (HID_WR) begin
      hid_r[HID_CTRL] <= HID_DATA;
    end
  end

  // Command host identity; rights keyed by identifier
  wire [`SRG_HOSTID_W-1:0] cmd_hid = hid_r[CMD_CTRL];

  // ---------------------------------------------------------------
  // Namespace state: registration per host slot
  // ---------------------------------------------------------------
  // One slot per controller, so every controller can register
  logic [`SRG_NUM_CTRL-1:0] reg_r     [`SRG_NUM_NS];
  logic [`SRG_KEY_W-1:0]    key_r     [`SRG_NUM_NS][`SRG_NUM_CTRL];
  logic [`SRG_HOSTID_W-1:0] slot_hid_r[`SRG_NUM_NS][`SRG_NUM_CTRL];
  logic [2:0]               rtype_r   [`SRG_NUM_NS];
  logic [`SRG_HOSTID_W-1:0] holder_r  [`SRG_NUM_NS];
  logic [`SRG_NUM_NS-1:0]   power_loss_persistence_state_r;

  // Match the command host against registered slots of the namespace
  logic [`SRG_NUM_CTRL-1:0] hit;
  logic [`SRG_NUM_CTRL-1:0] free;
  genvar g;
  generate
    for (g = 0; g < `SRG_NUM_CTRL; g++) begin : g_slot
      assign hit[g]  = reg_r[CMD_NS][g] &&
                       (slot_hid_r[CMD_NS][g] == cmd_hid);
      assign free[g] = !reg_r[CMD_NS][g];
    end
  endgenerate

  logic [`SRG_CTRL_W-1:0] hit_idx;
  logic [`SRG_CTRL_W-1:0] free_idx;
  always_comb begin
    hit_idx  = '0;
    free_idx = '0;
    for (int i = `SRG_NUM_CTRL - 1; i >= 0; i--) begin
      if (hit[i]) hit_idx = i[`SRG_CTRL_W-1:0];
      if (free[i]) free_idx = i[`SRG_CTRL_W-1:0];
    end
  end

  wire is_reg     = |hit;
  wire key_match  = is_reg && (key_r[CMD_NS][hit_idx] == CMD_KEY);
  wire is_holder  = (rtype_r[CMD_NS] != 3'h0) &&
                    ((holder_r[CMD_NS] == cmd_hid) ||
                     (is_reg && (rtype_r[CMD_NS] >= 3'h5)));

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire op_reg  = (CMD_OPCODE == `SRG_OP_RES_REG);
  wire op_rpt  = (CMD_OPCODE == `SRG_OP_RES_RPT);
  wire op_acq  = (CMD_OPCODE == `SRG_OP_RES_ACQ);
  wire op_rel  = (CMD_OPCODE == `SRG_OP_RES_REL);
  wire op_res  = op_reg || op_rpt || op_acq || op_rel;
  wire op_rd   = (CMD_OPCODE == `SRG_OP_READ) ||
                 (CMD_OPCODE == `SRG_OP_COMPARE);
  // Same setting for all controllers
  wire ns_cap  = CTRL_RES_EN && NS_RES_EN[CMD_NS];

  logic allow;
  srg_access_check u_check (
    .is_read       (op_rd),
    .rtype         (srg_pkg::srg_rtype_type'(rtype_r[CMD_NS])),
    .is_holder     (is_holder),
    .is_registrant (is_reg),
    .allow         (allow)
  );

  // Register: new key (action 0), unregister (1), replace (2)
  wire reg_new   = op_reg && (CMD_ACTION == 3'h0);
  wire reg_unreg = op_reg && (CMD_ACTION == 3'h1) && key_match;
  wire reg_repl  = op_reg && (CMD_ACTION == 3'h2) && key_match;
  wire reg_bad   = reg_new && is_reg && !key_match;
  wire acq_ok    = op_acq && key_match &&
                   ((rtype_r[CMD_NS] == 3'h0) || is_holder);
  wire rel_ok    = op_rel && key_match;
  wire res_fail  = (op_reg && !reg_new && !reg_unreg && !reg_repl) ||
                   reg_bad || (op_acq && !acq_ok) ||
                   (op_rel && !rel_ok);
  // Host identifier must be set first
  wire no_hid    = !hid_set_r[CMD_CTRL];

  logic [7:0] status_nxt;
  assign status_nxt =
    (op_res && !ns_cap)         ? `SRG_ST_BAD_OP :
    (op_res && (no_hid || res_fail)) ? `SRG_ST_CONFLICT :
    (!op_res && !allow)         ? `SRG_ST_CONFLICT :
                                  `SRG_ST_OK;

  wire accept  = CMD_VALID && (status_nxt == `SRG_ST_OK);
  // Media only for non-reservation commands that passed
  wire media_nxt = accept && !op_res;

  // ---------------------------------------------------------------
  // State update
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int n = 0; n < `SRG_NUM_NS; n++) begin
        reg_r[n]   <= '0;
        rtype_r[n] <= 3'h0;
      end
    end else if (accept && op_reg) begin
      if (reg_new && !is_reg)
        reg_r[CMD_NS][free_idx] <= 1'b1;
      else if (reg_unreg)
        reg_r[CMD_NS][hit_idx] <= 1'b0;
    end else if (accept && op_acq) begin
      rtype_r[CMD_NS] <= CMD_RTYPE;
    end else if (accept && op_rel) begin
      rtype_r[CMD_NS] <= 3'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (accept && reg_new && !is_reg) begin
      key_r[CMD_NS][free_idx]      <= CMD_KEY;
      slot_hid_r[CMD_NS][free_idx] <= cmd_hid;
    end else if (accept && reg_repl) begin
      key_r[CMD_NS][hit_idx] <= CMD_KEY;
    end
    if (accept && op_acq) begin
      holder_r[CMD_NS] <= cmd_hid;
    end
  end

  // Persistence state per namespace, set by register command
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      power_loss_persistence_state_r <= '0;
    end else if (accept && op_reg && CMD_POWER_LOSS_PERSISTENCE_STATE_WR) begin
      power_loss_persistence_state_r[CMD_NS] <= CMD_POWER_LOSS_PERSISTENCE_STATE;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic [15:0]              optional_command_support_field_nxt;
  logic [8*`SRG_NUM_NS-1:0] reservation_capability_field_nxt;
  always_comb begin
    optional_command_support_field_nxt = `SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_BASE;
    optional_command_support_field_nxt[`SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_RES_BIT] = CTRL_RES_EN;
  end
  generate
    for (g = 0; g < `SRG_NUM_NS; g++) begin : g_cap
      assign reservation_capability_field_nxt[8*g +: 8] =
        NS_RES_EN[g] ? `SRG_RESERVATION_CAPABILITY_FIELD_VAL : 8'h00;
    end
  endgenerate

  // Notification when a release drops a reservation held
  wire notify_nxt = accept && op_rel && (rtype_r[CMD_NS] != 3'h0);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      DONE     <= 1'b0;
      STATUS   <= `SRG_ST_OK;
      MEDIA_GO <= 1'b0;
      NOTIFY   <= 1'b0;
      OPTIONAL_COMMAND_SUPPORT_FIELD <= `SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_BASE;
      RESERVATION_CAPABILITY_FIELD   <= '0;
      POWER_LOSS_PERSISTENCE_STATE   <= '0;
    end else begin
      DONE     <= CMD_VALID;
      STATUS   <= CMD_VALID ? status_nxt : `SRG_ST_OK;
      MEDIA_GO <= media_nxt;
      NOTIFY   <= notify_nxt;
      OPTIONAL_COMMAND_SUPPORT_FIELD <= optional_command_support_field_nxt;
      RESERVATION_CAPABILITY_FIELD   <= reservation_capability_field_nxt;
      POWER_LOSS_PERSISTENCE_STATE   <= power_loss_persistence_state_r & NS_RES_EN;
    end
  end

endmodule

/* File: design/srg_params.svh */
// Constants for the shared namespace reservation gate.
// Assumes inclusion by bare name from design files.
`ifndef SRG_PARAMS_SVH
`define SRG_PARAMS_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define SRG_NUM_CTRL      4
`define SRG_NUM_NS        4
`define SRG_CTRL_W        2
`define SRG_NS_W          2
`define SRG_HOSTID_W      64
`define SRG_KEY_W         64

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define SRG_OP_READ       8'h02
`define SRG_OP_COMPARE    8'h05
`define SRG_OP_RES_REG    8'h0D
`define SRG_OP_RES_RPT    8'h0E
`define SRG_OP_RES_ACQ    8'h11
`define SRG_OP_RES_REL    8'h15

// ---------------------------------------------------------------
// Status codes
// ---------------------------------------------------------------
`define SRG_ST_OK         8'h00
`define SRG_ST_BAD_OP     8'h01
`define SRG_ST_CONFLICT   8'h83

// ---------------------------------------------------------------
// Capability fields
// ---------------------------------------------------------------
`define SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_RES_BIT  5
`define SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_BASE     16'h0000
`define SRG_RESERVATION_CAPABILITY_FIELD_VAL    8'h3F

`endif

/* File: design/srg_pkg.sv */
// Types for the shared namespace reservation gate.
// Assumes the params header is compiled alongside.
package srg_pkg;

  // ---------------------------------------------------------------
  // Reservation types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRG_RT_NONE    = 3'h0,
    SRG_RT_WE      = 3'h1,
    SRG_RT_EA      = 3'h2,
    SRG_RT_WE_RO   = 3'h3,
    SRG_RT_EA_RO   = 3'h4,
    SRG_RT_WE_AR   = 3'h5,
    SRG_RT_EA_AR   = 3'h6
  } srg_rtype_type;

  typedef enum logic [1:0] {
    SRG_CMD_IO,
    SRG_CMD_READ,
    SRG_CMD_RES
  } srg_class_type;

endpackage

/* File: test/srg_gate_chk.sv */
// Port assertions for the reservation gate.
// Assumes binding to srg_gate by the statement at the foot.
`timescale 1ns/1ps
`include "srg_params.svh"
module srg_gate_chk (
  // Clock and reset
  input wire logic                      CLOCK,
  input wire logic                      RST_N,
  // Inputs
  input wire logic                      CTRL_RES_EN,
  input wire logic [`SRG_NUM_NS-1:0]    NS_RES_EN,
  input wire logic                      CMD_VALID,
  input wire logic [`SRG_NS_W-1:0]      CMD_NS,
  input wire logic [7:0]                CMD_OPCODE,
  // Outputs
  input wire logic                      DONE,
  input wire logic [7:0]                STATUS,
  input wire logic                      MEDIA_GO,
  input wire logic                      NOTIFY,
  input wire logic [15:0]               OPTIONAL_COMMAND_SUPPORT_FIELD,
  input wire logic [8*`SRG_NUM_NS-1:0]  RESERVATION_CAPABILITY_FIELD
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  wire res_op = CMD_OPCODE inside {`SRG_OP_RES_REG, `SRG_OP_RES_RPT,
                                   `SRG_OP_RES_ACQ, `SRG_OP_RES_REL};
  wire supp   = CTRL_RES_EN && NS_RES_EN[CMD_NS];
  function automatic logic [8*`SRG_NUM_NS-1:0] cap_of(
    input logic [`SRG_NUM_NS-1:0] en);
    cap_of = '0;
    for (int i = 0; i < `SRG_NUM_NS; i++) begin
      cap_of[8*i+:8] = en[i] ? `SRG_RESERVATION_CAPABILITY_FIELD_VAL : 8'h00;
    end
  endfunction
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence res_cmd_s;
    CMD_VALID && res_op;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  verdict_lat_a: assert property (CMD_VALID |=> DONE)
    else $error("no verdict one cycle after command");
  no_stray_a: assert property (DONE |-> $past(CMD_VALID))
    else $error("verdict without command");
  bad_opcode_a: assert property (res_cmd_s ##0 !supp |=>
    DONE && STATUS == `SRG_ST_BAD_OP) else $error("unsupported op passed");
  res_supported_a: assert property (res_cmd_s ##0 supp |=>
    STATUS != `SRG_ST_BAD_OP && !MEDIA_GO) else $error("supported op bad");
  conflict_block_a: assert property (DONE && STATUS == `SRG_ST_CONFLICT
    |-> !MEDIA_GO && !NOTIFY) else $error("conflict reached media");
  media_ok_a: assert property (MEDIA_GO |-> DONE &&
    STATUS == `SRG_ST_OK && !$past(res_op)) else $error("media go wrong");
  notify_rel_a: assert property (NOTIFY |-> DONE &&
    $past(CMD_OPCODE) == `SRG_OP_RES_REL) else $error("stray notify");
  optional_command_support_field_bit_a: assert property ($past(RST_N) |->
    OPTIONAL_COMMAND_SUPPORT_FIELD[`SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_RES_BIT] == $past(CTRL_RES_EN))
    else $error("support bit wrong");
  reservation_capability_field_val_a: assert property ($past(RST_N) |->
    RESERVATION_CAPABILITY_FIELD == cap_of($past(NS_RES_EN)))
    else $error("capability field wrong");
  idle_status_a: assert property (!DONE |-> STATUS == `SRG_ST_OK)
    else $error("status without verdict");
endmodule
bind srg_gate srg_gate_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .CTRL_RES_EN(CTRL_RES_EN), .NS_RES_EN(NS_RES_EN), .CMD_VALID(CMD_VALID),
  .CMD_NS(CMD_NS), .CMD_OPCODE(CMD_OPCODE), .DONE(DONE), .STATUS(STATUS),
  .MEDIA_GO(MEDIA_GO), .NOTIFY(NOTIFY),
  .OPTIONAL_COMMAND_SUPPORT_FIELD(OPTIONAL_COMMAND_SUPPORT_FIELD),
  .RESERVATION_CAPABILITY_FIELD(RESERVATION_CAPABILITY_FIELD));

/* File: test/srg_gate_tb.sv */
// Self-checking bench for the reservation gate.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "srg_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module srg_gate_tb;
  logic        clock, rst_n, ctrl_en, hid_wr, cmd_valid, cmd_pw;
  logic        done, media_go, notify;
  logic [3:0]  ns_en, power_loss_persistence_state;
  logic [1:0]  hid_ctrl, cmd_ctrl, cmd_ns;
  logic [2:0]  cmd_act, cmd_rt;
  logic [7:0]  cmd_op, status;
  logic [63:0] hid_data, cmd_key, key_a, key_b;
  logic [15:0] optional_command_support_field;
  logic [31:0] reservation_capability_field;
  logic [7:0]  ops [4] = '{`SRG_OP_RES_REG, `SRG_OP_RES_RPT,
                           `SRG_OP_RES_ACQ, `SRG_OP_RES_REL};
  int          n_fail = 0, comparisons = 0;
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  srg_host_model u_host (.clk(clock), .hid_wr(hid_wr), .hid_ctrl(hid_ctrl),
    .hid_data(hid_data), .cmd_valid(cmd_valid), .cmd_ctrl(cmd_ctrl),
    .cmd_ns(cmd_ns), .cmd_op(cmd_op), .cmd_act(cmd_act), .cmd_rt(cmd_rt),
    .cmd_key(cmd_key), .cmd_pw(cmd_pw));
  srg_gate u_dut (.CLOCK(clock), .RST_N(rst_n), .CTRL_RES_EN(ctrl_en),
    .NS_RES_EN(ns_en), .HID_WR(hid_wr), .HID_CTRL(hid_ctrl),
    .HID_DATA(hid_data), .CMD_VALID(cmd_valid), .CMD_CTRL(cmd_ctrl),
    .CMD_NS(cmd_ns), .CMD_OPCODE(cmd_op), .CMD_ACTION(cmd_act),
    .CMD_RTYPE(cmd_rt), .CMD_KEY(cmd_key), .CMD_POWER_LOSS_PERSISTENCE_STATE(cmd_pw),
    .CMD_POWER_LOSS_PERSISTENCE_STATE_WR(cmd_pw), .DONE(done), .STATUS(status), .MEDIA_GO(media_go),
    .NOTIFY(notify), .OPTIONAL_COMMAND_SUPPORT_FIELD(optional_command_support_field),
    .RESERVATION_CAPABILITY_FIELD(reservation_capability_field),
    .POWER_LOSS_PERSISTENCE_STATE(power_loss_persistence_state));
  // ---------------------------------------------------------------
  // Expectations and tasks
  // ---------------------------------------------------------------
  function automatic logic is_res(input logic [7:0] op);
    return op inside {`SRG_OP_RES_REG, `SRG_OP_RES_RPT,
                      `SRG_OP_RES_ACQ, `SRG_OP_RES_REL};
  endfunction
  function automatic logic [7:0] exp_st(input logic [7:0] op,
                                        input logic [1:0] n,
                                        input logic [7:0] st);
    if (is_res(op) && !(ctrl_en && ns_en[n])) return `SRG_ST_BAD_OP;
    return st;
  endfunction
  task run(input logic [1:0] c, n, input logic [7:0] op, input logic [2:0] r,
           input logic [63:0] k, input logic p, input logic [7:0] st,
           input logic nt);
    logic [7:0] s;
    s = exp_st(op, n, st);
    u_host.send(c, n, op, 3'h0, r, k, p);
    `CHK(done, 1'b1)
    `CHK(status, s)
    `CHK(media_go, s == `SRG_ST_OK && !is_res(op))
    `CHK(notify, nt)
  endtask
  task stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    key_a = $urandom(32'h21BCDD83);
    {rst_n, ctrl_en, ns_en} = {1'b0, 1'b1, 4'h7};
    repeat (6) @(posedge clock);
    #1 rst_n = 1;
    repeat (2) @(posedge clock);
    #1 `CHK(optional_command_support_field[`SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_RES_BIT], 1'b1)
    for (int i = 0; i < 4; i++) `CHK(reservation_capability_field[8*i+:8], ns_en[i] ? 8'h3F : 8'h00)
    for (int i = 0; i < 4; i++) run(0, 3, ops[i], 1, 0, 0, 0, 0);
    ctrl_en = 0;
    repeat (2) @(posedge clock);
    #1 `CHK(optional_command_support_field[`SRG_OPTIONAL_COMMAND_SUPPORT_FIELD_RES_BIT], 1'b0)
    for (int i = 0; i < 4; i++) run(0, 0, ops[i], 1, 0, 0, 0, 0);
    ctrl_en = 1;
    key_a = {$urandom, $urandom};
    key_b = {$urandom, $urandom};
    u_host.set_hid(0, 64'hA1);
    u_host.set_hid(1, 64'hA1);
    u_host.set_hid(2, 64'hB2);
    run(0, 0, `SRG_OP_RES_REG, 0, key_a, 1, `SRG_ST_OK, 0);
    // Persistence output trails the register verdict by one cycle
    @(posedge clock);
    #1 `CHK(power_loss_persistence_state[0], 1'b1)
    run(0, 0, `SRG_OP_RES_ACQ, 2, key_a, 0, `SRG_ST_OK, 0);
    run(1, 0, `SRG_OP_READ, 0, 0, 0, `SRG_ST_OK, 0);
    run(2, 0, `SRG_OP_READ, 0, 0, 0, `SRG_ST_CONFLICT, 0);
    run(2, 0, `SRG_OP_COMPARE, 0, 0, 0, `SRG_ST_CONFLICT, 0);
    run(2, 0, `SRG_OP_RES_REG, 0, key_b, 0, `SRG_ST_OK, 0);
    run(2, 0, `SRG_OP_RES_RPT, 0, key_b, 0, `SRG_ST_OK, 0);
    run(2, 0, `SRG_OP_RES_ACQ, 1, key_b, 0, `SRG_ST_CONFLICT, 0);
    run(1, 0, `SRG_OP_RES_REL, 2, key_a, 0, `SRG_ST_OK, 1);
    run(2, 0, `SRG_OP_READ, 0, 0, 0, `SRG_ST_OK, 0);
    for (int i = 0; i < 20; i++)
      run($urandom_range(0, 3), $urandom_range(1, 2), $urandom_range(0, 1) ?
          `SRG_OP_READ : `SRG_OP_COMPARE, 0, {$urandom, $urandom}, 0,
          `SRG_ST_OK, 0);
    stop_test();
  end
endmodule

/* File: test/srg_host_model.sv */
// Host side model: sets host ids and submits commands.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module srg_host_model (
  // Clock
  input  wire logic  clk,
  // Host id and command
  output logic       hid_wr,
  output logic [1:0] hid_ctrl,
  output logic [63:0] hid_data,
  output logic       cmd_valid,
  output logic [1:0] cmd_ctrl,
  output logic [1:0] cmd_ns,
  output logic [7:0] cmd_op,
  output logic [2:0] cmd_act,
  output logic [2:0] cmd_rt,
  output logic [63:0] cmd_key,
  output logic       cmd_pw
);
  initial begin
    {hid_wr, hid_ctrl, hid_data, cmd_valid, cmd_ctrl, cmd_ns} = '0;
    {cmd_op, cmd_act, cmd_rt, cmd_key, cmd_pw} = '0;
  end
  // Host id goes first on each controller used
  task set_hid(input logic [1:0] c, input logic [63:0] id);
    @(posedge clk); #1;
    {hid_wr, hid_ctrl, hid_data} = {1'b1, c, id};
    @(posedge clk); #1;
    {hid_wr, hid_data} = {1'b0, ~id};
  endtask
  task send(input logic [1:0] c, n, input logic [7:0] op,
            input logic [2:0] a, r, input logic [63:0] k, input logic p);
    @(posedge clk); #1;
    {cmd_valid, cmd_ctrl, cmd_ns, cmd_op} = {1'b1, c, n, op};
    {cmd_act, cmd_rt, cmd_key, cmd_pw} = {a, r, k, p};
    @(posedge clk); #1;
    {cmd_valid, cmd_key, cmd_pw} = {1'b0, ~k, 1'b0};
  endtask
endmodule
